// File: hs_digital_io_control_bench.sv
`timescale 1ns/1ns
module hs_digital_io_control_bench;
   reg         core_clk;
   reg         rst_b;
   reg  [7:0]  io_addr;
   reg         io_rd;
   reg         io_wr;
   reg  [31:0] io_wdata;
   reg  [2:0]  tmr_out;
   reg  [31:0] out_q_data;
   reg         out_q_valid;
   reg         in_q_ready;
   reg         start_trig;
   reg         ok;
   wire [31:0] io_rdata;
   wire [31:0] din;
   wire [31:0] dout;
   wire [31:0] in_q_data;
   wire [31:0] tmr_wdata;
   wire [31:0] aux_out;
   wire [1:0]  tmr_sel;
   wire        chain_timer_zero, chain_timer_one;
   wire        in_req, in_ack, out_req, out_ack, out_q_take, in_q_valid, soft_trigger_pin, irq;
   integer     n_errors, tests_run, cyc, n_take, i;
   hsdio_ctrl DUT (.core_clk, .rst_b, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .tmr_sel, .tmr_rd(),
      .tmr_wr(), .tmr_wdata, .tmr_rdata(32'h0000_0C35), .tmr_out, .chain_timer_zero, .chain_timer_one,
      .din, .in_req, .in_ack, .start_trig, .dout, .out_req, .out_ack, .soft_trigger_pin, .aux_in(32'h5A5A_0F0F),
      .aux_out, .out_q_data, .out_q_valid, .out_q_take, .in_q_data, .in_q_valid, .in_q_ready, .irq);
   hsdio_far_dev far (.core_clk, .din, .in_req, .in_ack, .out_req, .out_ack);
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // the bus side of the output queue advances on every take
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (out_q_take === 1'b1) begin
         out_q_data <= out_q_data + 32'h1;
         n_take <= n_take + 1;
      end
      if (cyc == 30000) begin
         n_errors = n_errors + 1;
         end_of_test;
      end
   end
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", tests_run, n_errors);
         if (n_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // whole words only
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge core_clk) #1;
         io_wr = 1'b1;
         io_addr = a;
         io_wdata = d;
         @(posedge core_clk) #1;
         io_wr = 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         @(posedge core_clk) #1;
         io_rd = 1'b1;
         io_addr = a;
         @(posedge core_clk) #1;
         io_rd = 1'b0;
         chk(io_rdata, e);
      end
   endtask
   task pop;
      begin
         @(posedge core_clk) #1;
         in_q_ready = 1'b1;
         @(posedge core_clk) #1;
         in_q_ready = 1'b0;
      end
   endtask
   // one timer output pulse, long enough to cross the pin synchronisers
   task pulse(input [2:0] m);
      begin
         @(posedge core_clk) #1;
         tmr_out = m;
         repeat (3) @(posedge core_clk);
         #1 tmr_out = 3'h0;
         repeat (4) @(posedge core_clk);
      end
   endtask
   task t_basic;
      begin
         rd(8'h18, 32'h0000_0000);
         rd(8'h1C, 32'h0000_4000);
         rd(8'h24, 32'h0000_0000);
         rd(8'h0C, 32'h0000_0000);
         wr(8'h0C, 32'h0000_0036);
         chk(tmr_wdata, 32'h0000_0036);
         rd(8'h04, 32'h0000_0C35);
         chk({30'h0000_0000, tmr_sel}, 32'h0000_0001);
         wr(8'h18, 32'hFFFF_F800);
         rd(8'h18, 32'h0000_0800);
         chk({31'h0000_0000, soft_trigger_pin}, 32'h0000_0001);
         wr(8'h18, 32'h0000_0000);
         rd(8'h18, 32'h0000_0000);
         chk({31'h0000_0000, soft_trigger_pin}, 32'h0000_0000);
         wr(8'h1C, 32'h0000_0C00);
         rd(8'h1C, 32'h0000_4C00);
         chk({30'h0000_0000, chain_timer_one, chain_timer_zero}, 32'h0000_0003);
         wr(8'h1C, 32'h0000_0000);
         wr(8'h14, 32'hA5A5_5A5A);
         rd(8'h14, 32'hA5A5_5A5A);
         chk(dout, 32'hA5A5_5A5A);
         rd(8'h10, far.din);
         wr(8'h20, 32'h1234_ABCD);
         chk(aux_out, 32'h1234_ABCD);
         rd(8'h20, 32'h5A5A_0F0F);
         $display("t_basic done");
      end
   endtask
   task t_strobe;
      begin
         wr(8'h18, 32'h0000_004B);
         far.send(32'h1234_5678, ok);
         chk({31'h0000_0000, ok}, 32'h0000_0001);
         chk(in_q_data, 32'h1234_5678);
         chk({31'h0000_0000, in_q_valid}, 32'h0000_0001);
         pop;
         chk({31'h0000_0000, in_q_valid}, 32'h0000_0000);
         wr(8'h18, 32'h0000_000B);
         far.send(32'h0BAD_0BAD, ok);
         chk({31'h0000_0000, ok}, 32'h0000_0000);
         chk({31'h0000_0000, in_q_valid}, 32'h0000_0000);
         rd(8'h1C, 32'h0000_4000);
         $display("t_strobe done");
      end
   endtask
   task t_irq;
      begin
         wr(8'h1C, 32'h0000_1002);
         wr(8'h18, 32'h0000_004A);
         far.send(32'h00C0_FFEE, ok);
         chk(in_q_data, 32'h00C0_FFEE);
         chk({31'h0000_0000, irq}, 32'h0000_0001);
         rd(8'h1C, 32'h0000_1042);
         wr(8'h1C, 32'h0000_13E0);
         rd(8'h1C, 32'h0000_1000);
         chk({31'h0000_0000, irq}, 32'h0000_0000);
         pop;
         wr(8'h1C, 32'h0000_0000);
         wr(8'h18, 32'h0000_0000);
         $display("t_irq done");
      end
   endtask
   task t_oq;
      begin
         far.ack_dly = 3;
         out_q_valid = 1'b1;
         wr(8'h18, 32'h0000_0580);
         repeat (60) @(posedge core_clk);
         #1 out_q_valid = 1'b0;
         repeat (20) @(posedge core_clk);
         chk(n_take, far.n_ack);
         chk({31'h0000_0000, n_take > 2 && n_take < 12}, 32'h0000_0001);
         wr(8'h14, 32'hFFFF_FFFF);
         rd(8'h18, 32'h0001_0580);
         chk(dout, out_q_data - 32'h0000_0001);
         // stop the output side first: a load attempt in the clearing cycle would set the flag again
         wr(8'h18, 32'h0000_0000);
         wr(8'h18, 32'h0001_0000);
         rd(8'h18, 32'h0000_0000);
         $display("t_oq done");
      end
   endtask
   task t_fill;
      begin
         wr(8'h18, 32'h0000_004C);
         for (i = 0; i < 2049; i = i + 1) begin
            pulse(3'h1);
         end
         rd(8'h1C, 32'h0000_8000);
         rd(8'h18, 32'h0000_404C);
         chk(in_q_data, far.din);
         wr(8'h18, 32'h0000_4000);
         rd(8'h18, 32'h0000_0000);
         wr(8'h1C, 32'h0000_2000);
         rd(8'h1C, 32'h0000_4000);
         $display("t_fill done");
      end
   endtask
   task t_pace;
      begin
         wr(8'h18, 32'h0000_007C);
         pulse(3'h1);
         chk({31'h0000_0000, in_q_valid}, 32'h0000_0000);
         @(posedge core_clk) #1;
         start_trig = 1'b1;
         pulse(3'h1);
         chk({31'h0000_0000, in_q_valid}, 32'h0000_0001);
         chk(in_q_data, far.din);
         pop;
         i = n_take;
         out_q_valid = 1'b1;
         wr(8'h18, 32'h0000_0600);
         repeat (4) @(posedge core_clk);
         chk(n_take, i);
         pulse(3'h2);
         chk(n_take, i + 1);
         chk(dout, out_q_data - 32'h0000_0001);
         #1 out_q_valid = 1'b0;
         pulse(3'h2);
         rd(8'h18, 32'h0001_0600);
         wr(8'h18, 32'h0001_0000);
         $display("t_pace done");
      end
   endtask
   initial begin
      rst_b = 1'b0;
      io_addr = 8'h00;
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_wdata = 32'h0000_0000;
      tmr_out = 3'h0;
      out_q_data = 32'hC0DE_0000;
      out_q_valid = 1'b0;
      in_q_ready = 1'b0;
      start_trig = 1'b0;
      n_errors = 0;
      tests_run = 0;
      cyc = 0;
      n_take = 0;
      repeat (5) @(posedge core_clk);
      #1 rst_b = 1'b1;
      t_basic;
      t_strobe;
      t_irq;
      t_oq;
      t_fill;
      t_pace;
      end_of_test;
   end
endmodule

// File: hsdio_ctrl.v
// How it works
// - nine words decoded at offsets 0 to 20
// - input word read returns 32 channels
// - output write drives pins, read returns them
// - input ack after host read or queue write
// - request strobe edge latches input word
// - timer zero falling edge samples inputs
// - sampled words go into input queue
// - external start edge gates input sampling
// - input enable low stops sampling and input ack
// - output waits for ack before next queued word
// - output request strobe on each new word
// - timer one falling edge moves next queued word
// - queue mode ignores direct output writes
// - soft trigger pin follows control bit
// - overrun flag on full queue, write-one clears
// - underrun flag on empty queue, write-one clears
// - five interrupt enables gate their sources
// - sticky interrupt status, write-one clears
// - chain bits route timer two to clocks
// - edge select bit picks strobe edge
// - queue clear bit, empty and full flags
// - request held until ack, ack until release
`timescale 1ns/1ns
`include "hsdio_regs.vh"

module hsdio_ctrl (
   // clock and reset
   input  wire        core_clk,
   input  wire        rst_b,
   // host i/o port
   input  wire [7:0]  io_addr,
   input  wire        io_rd,
   input  wire        io_wr,
   input  wire [31:0] io_wdata,
   output wire [31:0] io_rdata,
   // interval timer access
   output wire [1:0]  tmr_sel,
   output wire        tmr_rd,
   output wire        tmr_wr,
   output wire [31:0] tmr_wdata,
   input  wire [31:0] tmr_rdata,
   input  wire [2:0]  tmr_out,
   output wire        chain_timer_zero,
   output wire        chain_timer_one,
   // parallel input pins
   input  wire [31:0] din,
   input  wire        in_req,
   output wire        in_ack,
   input  wire        start_trig,
   // parallel output pins
   output wire [31:0] dout,
   output wire        out_req,
   input  wire        out_ack,
   output wire        soft_trigger_pin,
   // auxiliary pins
   input  wire [31:0] aux_in,
   output wire [31:0] aux_out,
   // output word queue, filled by the bus side
   input  wire [31:0] out_q_data,
   input  wire        out_q_valid,
   output wire        out_q_take,
   // input word queue, drained by the bus side
   output wire [31:0] in_q_data,
   output wire        in_q_valid,
   input  wire        in_q_ready,
   // interrupt request
   output wire        irq
);

   localparam SW = 70;

   // pin synchronisers; prev_q only gives edge history
   reg  [SW-1:0] meta_q;
   reg  [SW-1:0] sync_q;
   reg  [SW-1:0] prev_q;

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= {SW{1'b0}};
         sync_q <= {SW{1'b0}};
         prev_q <= {SW{1'b0}};
      end else begin
         meta_q <= {aux_in, din, tmr_out, out_ack, start_trig, in_req};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   wire        req_s    = sync_q[0];
   wire        req_p    = prev_q[0];
   wire        trig_s   = sync_q[1];
   wire        trig_p   = prev_q[1];
   wire        oack_s   = sync_q[2];
   wire        oack_p   = prev_q[2];
   wire [2:0]  tmr_s    = sync_q[5:3];
   wire [2:0]  tmr_p    = prev_q[5:3];
   wire [31:0] din_s    = sync_q[37:6];
   wire [31:0] aux_s    = sync_q[69:38];

   wire        timer_zero_output = tmr_s[0];

   // control and status state
   reg  [11:0] ctl_q;
   reg         input_overrun_flag;
   reg         output_underrun_flag;
   reg  [4:0]  ien_q;
   reg  [4:0]  ist_q;
   reg         chain0_q;
   reg         chain1_q;
   reg         strobe_edge_select;
   reg  [31:0] dout_q;
   reg  [31:0] aux_q;
   reg  [31:0] rdata_q;
   reg         armed_q;
   reg         in_ack_q;
   reg         out_req_q;
   reg         wait_q;

   wire in_ack_en            = ctl_q[`HSDIO_X_IN_ACK];
   wire in_stb_en            = ctl_q[`HSDIO_X_IN_STB];
   wire input_pacer_en       = ctl_q[`HSDIO_X_IN_PACE];
   wire in_q_en              = ctl_q[`HSDIO_X_IN_Q];
   wire start_edge_polarity  = ctl_q[`HSDIO_X_TRG_POL];
   wire external_start_en    = ctl_q[`HSDIO_X_TRG_EN];
   wire in_en                = ctl_q[`HSDIO_X_IN_EN];
   wire out_ack_en           = ctl_q[`HSDIO_X_OUT_ACK];
   wire out_req_en           = ctl_q[`HSDIO_X_OUT_REQ];
   wire output_pacer_en      = ctl_q[`HSDIO_X_OUT_PACE];
   wire out_q_en             = ctl_q[`HSDIO_X_OUT_Q];

   // address decode
   wire hit_cnt  = (io_addr == `HSDIO_OFS_CNT0) |
                   (io_addr == `HSDIO_OFS_CNT1) |
                   (io_addr == `HSDIO_OFS_CNT2);
   wire hit_tcw  = (io_addr == `HSDIO_OFS_TCW);
   wire hit_din  = (io_addr == `HSDIO_OFS_DIN);
   wire hit_dout = (io_addr == `HSDIO_OFS_DOUT);
   wire hit_xfer = (io_addr == `HSDIO_OFS_XFER);
   wire hit_irq  = (io_addr == `HSDIO_OFS_IRQ);
   wire hit_aux  = (io_addr == `HSDIO_OFS_AUX);

   wire wr_dout  = io_wr & hit_dout;
   wire wr_xfer  = io_wr & hit_xfer;
   wire wr_irq   = io_wr & hit_irq;
   wire wr_aux   = io_wr & hit_aux;
   wire rd_din   = io_rd & hit_din;

   // timer words pass straight through to the interval timer
   assign tmr_sel   = io_addr[3:2];
   assign tmr_rd    = io_rd & hit_cnt;
   assign tmr_wr    = io_wr & (hit_cnt | hit_tcw);
   assign tmr_wdata = io_wdata;

   // edges seen on the synchronised pins
   wire req_rise  = req_s & ~req_p;
   wire req_fall  = ~req_s & req_p;
   wire trig_rise = trig_s & ~trig_p;
   wire trig_fall = ~trig_s & trig_p;
   wire oack_rise = oack_s & ~oack_p;
   wire t0_fall   = ~timer_zero_output & tmr_p[0];
   wire t1_fall   = ~tmr_s[1] & tmr_p[1];
   wire [2:0] tmr_rise = tmr_s & ~tmr_p;

   wire strobe_ev = strobe_edge_select ? req_fall : req_rise;
   wire trig_ev   = start_edge_polarity ? trig_rise : trig_fall;

   // input sampling
   wire sample_ev = in_en & armed_q &
                    ((in_stb_en & strobe_ev) |
                     (input_pacer_en & t0_fall));

   wire q_full;
   wire q_empty;
   wire q_clr     = wr_irq & io_wdata[`HSDIO_I_QCLR];
   wire q_push    = sample_ev & in_q_en & ~q_full;
   wire ovr_ev    = sample_ev & in_q_en & q_full;
   wire ack_ev    = in_ack_en & in_en & (q_push | rd_din);

   // request idle level is the opposite of the active edge
   wire req_idle  = (req_s == strobe_edge_select);

   hsdio_fifo #(
      .W  (32),
      .AW (`HSDIO_Q_AW)
   ) u_in_queue (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .clr       (q_clr),
      .push      (q_push),
      .push_data (din_s),
      .full      (q_full),
      .pop       (in_q_ready),
      .pop_data  (in_q_data),
      .empty     (q_empty)
   );

   assign in_q_valid = ~q_empty;

   // output pacing
   wire load_ev   = out_q_en & ~wait_q &
                    (output_pacer_en ? t1_fall : 1'b1);
   wire take      = load_ev & out_q_valid;
   wire und_ev    = load_ev & ~out_q_valid &
                    (output_pacer_en | out_ack_en);
   wire host_word = wr_dout & ~out_q_en;
   wire new_word  = take | host_word;

   assign out_q_take = take;

   // interrupt sources: oack, input request, timers 0..2
   wire [4:0] irq_src = {tmr_rise, strobe_ev, oack_rise};
   wire [4:0] ist_clr = wr_irq ? io_wdata[`HSDIO_I_ST_HI:`HSDIO_I_ST_LO] : 5'h0_0;

   // control registers
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl_q              <= `HSDIO_CTL_RST;
         ien_q              <= 5'h0_0;
         chain0_q           <= 1'b0;
         chain1_q           <= 1'b0;
         strobe_edge_select <= 1'b0;
         aux_q              <= `HSDIO_ZERO;
      end else begin
         if (wr_xfer) begin
            ctl_q <= io_wdata[11:0];
         end
         if (wr_irq) begin
            ien_q              <= io_wdata[`HSDIO_I_EN_HI:`HSDIO_I_EN_LO];
            chain0_q           <= io_wdata[`HSDIO_I_CHAIN0];
            chain1_q           <= io_wdata[`HSDIO_I_CHAIN1];
            strobe_edge_select <= io_wdata[`HSDIO_I_EDGE];
         end
         if (wr_aux) begin
            aux_q <= io_wdata;
         end
      end
   end

   // sticky flags: a new event beats a write-one clear in the same cycle
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         input_overrun_flag   <= 1'b0;
         output_underrun_flag <= 1'b0;
         ist_q                <= 5'h0_0;
      end else begin
         if (ovr_ev) begin
            input_overrun_flag <= 1'b1;
         end else if (wr_xfer & io_wdata[`HSDIO_X_OVR]) begin
            input_overrun_flag <= 1'b0;
         end
         if (und_ev) begin
            output_underrun_flag <= 1'b1;
         end else if (wr_xfer & io_wdata[`HSDIO_X_UND]) begin
            output_underrun_flag <= 1'b0;
         end
         ist_q <= (ist_q & ~ist_clr) | (irq_src & ien_q);
      end
   end

   // external start: armed by the chosen edge, dropped with input enable
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         armed_q <= 1'b0;
      end else if (!in_en) begin
         armed_q <= 1'b0;
      end else if (!external_start_en | trig_ev) begin
         armed_q <= 1'b1;
      end
   end

   // input acknowledge stays up until the request returns idle
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         in_ack_q <= 1'b0;
      end else if (ack_ev) begin
         in_ack_q <= 1'b1;
      end else if (!in_ack_en | req_idle) begin
         in_ack_q <= 1'b0;
      end
   end

   // output word and its handshake
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dout_q    <= `HSDIO_ZERO;
         out_req_q <= 1'b0;
         wait_q    <= 1'b0;
      end else begin
         if (take) begin
            dout_q <= out_q_data;
         end else if (host_word) begin
            dout_q <= io_wdata;
         end
         // without ack mode the request is a one-cycle strobe
         if (new_word & out_req_en) begin
            out_req_q <= 1'b1;
         end else if (!out_ack_en | oack_rise) begin
            out_req_q <= 1'b0;
         end
         if (new_word & out_ack_en) begin
            wait_q <= 1'b1;
         end else if (!out_ack_en | oack_rise) begin
            wait_q <= 1'b0;
         end
      end
   end

   // read data, registered one cycle after the read strobe
   reg [31:0] rd_d;

   always @* begin
      rd_d = `HSDIO_ZERO;
      if (hit_cnt) begin
         rd_d = tmr_rdata;
      end else if (hit_din) begin
         rd_d = din_s;
      end else if (hit_dout) begin
         rd_d = dout_q;
      end else if (hit_xfer) begin
         rd_d = {15'h0000, output_underrun_flag, 1'b0,
                 input_overrun_flag, 2'b00, ctl_q};
      end else if (hit_irq) begin
         rd_d = {16'h0000, q_full, q_empty, 1'b0,
                 strobe_edge_select, chain1_q, chain0_q,
                 ist_q, ien_q};
      end else if (hit_aux) begin
         rd_d = aux_s;
      end
   end

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= `HSDIO_ZERO;
      end else if (io_rd) begin
         rdata_q <= rd_d;
      end
   end

   // outputs
   assign io_rdata         = rdata_q;
   assign dout             = dout_q;
   assign in_ack           = in_ack_q;
   assign out_req          = out_req_q;
   assign soft_trigger_pin = ctl_q[`HSDIO_X_SOFT_TRG];
   assign chain_timer_zero = chain0_q;
   assign chain_timer_one  = chain1_q;
   assign aux_out          = aux_q;
   assign irq              = |ist_q;

endmodule

// File: hsdio_ctrl_asserts.sv
`timescale 1ns/1ns
module hsdio_ctrl_asserts (
   // clock and reset
   input wire        core_clk,
   input wire        rst_b,
   // host port
   input wire [7:0]  io_addr,
   input wire        io_rd,
   input wire        io_wr,
   input wire [31:0] io_wdata,
   input wire [31:0] io_rdata,
   input wire        tmr_rd,
   input wire        tmr_wr,
   // pins and queues
   input wire [31:0] din,
   input wire        in_req,
   input wire        in_ack,
   input wire [31:0] dout,
   input wire [31:0] out_q_data,
   input wire        out_q_valid,
   input wire        out_q_take,
   input wire        soft_trigger_pin,
   input wire        irq
);
   reg [1:0] din_age_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // pins cross two sync stages, so only a settled input can be compared
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         din_age_q <= 2'h0;
      end else if (!$stable(din)) begin
         din_age_q <= 2'h0;
      end else if (din_age_q != 2'h3) begin
         din_age_q <= din_age_q + 2'h1;
      end
   end
   tmr_read_a: assert property (tmr_rd == (io_rd && io_addr < 8'h0C && io_addr[1:0] == 2'h0))
      else $error("timer read decode wrong");
   tmr_write_a: assert property (tmr_wr == (io_wr && io_addr <= 8'h0C && io_addr[1:0] == 2'h0))
      else $error("timer write decode wrong");
   unmapped_read_a: assert property (io_rd && (io_addr > 8'h20 || io_addr[1:0] != 2'h0) |=> io_rdata == 32'h0)
      else $error("unmapped read not zero");
   ctl_word_a: assert property (io_rd && io_addr == 8'h0C |=> io_rdata == 32'h0)
      else $error("write-only word readable");
   din_read_a: assert property (io_rd && io_addr == 8'h10 && din_age_q == 2'h3 |=> io_rdata == $past(din, 2))
      else $error("input word read wrong");
   take_valid_a: assert property (out_q_take |-> out_q_valid)
      else $error("take from empty queue head");
   take_dout_a: assert property (out_q_take |=> dout == $past(out_q_data))
      else $error("queued word not on pins");
   ack_hold_a: assert property (in_ack && in_req && !io_wr |=> in_ack)
      else $error("ack dropped while request held");
   irq_clear_a: assert property (io_wr && io_addr == 8'h1C && io_wdata[9:0] == 10'h3E0 |-> ##[1:2] !irq)
      else $error("irq stays after clear");
   soft_pin_a: assert property (io_wr && io_addr == 8'h18 ##1 !io_wr [*2] |-> soft_trigger_pin == $past(io_wdata[11], 2))
      else $error("soft trigger pin wrong");
endmodule
bind hsdio_ctrl hsdio_ctrl_asserts u_chk (.core_clk, .rst_b, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata,
   .tmr_rd, .tmr_wr, .din, .in_req, .in_ack, .dout, .out_q_data, .out_q_valid, .out_q_take, .soft_trigger_pin, .irq);

// File: hsdio_far_dev.sv
`timescale 1ns/1ns
module hsdio_far_dev (
   // clock
   input  wire        core_clk,
   // input side
   output reg  [31:0] din,
   output reg         in_req,
   input  wire        in_ack,
   // output side
   input  wire        out_req,
   output reg         out_ack
);
   integer ack_dly;
   integer n_ack;
   integer w;
   initial begin
      din = 32'h0F0F_3C3C;
      in_req = 1'b0;
      out_ack = 1'b0;
      ack_dly = 2;
      n_ack = 0;
      w = 0;
   end
   // ack each word after ack_dly cycles, hold until request falls
   always @(posedge core_clk) begin
      if (out_req !== 1'b1) begin
         out_ack <= #1 1'b0;
         w <= 0;
      end else if (!out_ack && w < ack_dly) begin
         w <= w + 1;
      end else if (!out_ack) begin
         out_ack <= #1 1'b1;
         n_ack <= n_ack + 1;
      end
   end
   // data settles before the request and stays past its release
   task send(input [31:0] wd, output ok);
      integer i;
      begin
         @(posedge core_clk) #1;
         din = wd;
         repeat (3) @(posedge core_clk);
         #1 in_req = 1'b1;
         ok = 1'b0;
         for (i = 0; i < 16 && !ok; i = i + 1) begin
            @(posedge core_clk);
            ok = (in_ack === 1'b1);
         end
         #1 in_req = 1'b0;
         for (i = 0; i < 16 && in_ack !== 1'b0; i = i + 1)
            @(posedge core_clk);
         repeat (4) @(posedge core_clk);
         #1 din = ~wd;
      end
   endtask
endmodule

// File: hsdio_fifo.v
`timescale 1ns/1ns
`include "hsdio_regs.vh"

module hsdio_fifo #(
   parameter W  = 32,
   parameter AW = `HSDIO_Q_AW
) (
   // clock and reset
   input  wire          core_clk,
   input  wire          rst_b,
   // control
   input  wire          clr,
   // fill side
   input  wire          push,
   input  wire [W-1:0]  push_data,
   output wire          full,
   // drain side
   input  wire          pop,
   output wire [W-1:0]  pop_data,
   output wire          empty
);

   reg [W-1:0]  mem [0:(1<<AW)-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0]   cnt_q;

   wire do_push = push & ~full;
   wire do_pop  = pop & ~empty;

   assign full     = cnt_q[AW];
   assign empty    = (cnt_q == {(AW+1){1'b0}});
   assign pop_data = mem[rd_q];

   always @(posedge core_clk) begin
      if (do_push) begin
         mem[wr_q] <= push_data;
      end
   end

   // a clear drops everything, including a push in the same cycle
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else if (clr) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (do_push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (do_pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (do_push & ~do_pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (do_pop & ~do_push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule

// File: hsdio_regs.vh
`ifndef HSDIO_REGS_VH
`define HSDIO_REGS_VH

// word offsets on the host i/o port
`define HSDIO_OFS_CNT0   8'h00
`define HSDIO_OFS_CNT1   8'h04
`define HSDIO_OFS_CNT2   8'h08
`define HSDIO_OFS_TCW    8'h0C
`define HSDIO_OFS_DIN    8'h10
`define HSDIO_OFS_DOUT   8'h14
`define HSDIO_OFS_XFER   8'h18
`define HSDIO_OFS_IRQ    8'h1C
`define HSDIO_OFS_AUX    8'h20

`define HSDIO_ZERO       32'h0000_0000
`define HSDIO_CTL_RST    12'h000
`define HSDIO_CTL_MASK   32'h0000_0FFF

// on-board input queue: 2K samples
`define HSDIO_Q_DEPTH    2048
`define HSDIO_Q_AW       11

// transfer control word fields
`define HSDIO_X_IN_ACK   0
`define HSDIO_X_IN_STB   1
`define HSDIO_X_IN_PACE  2
`define HSDIO_X_IN_Q     3
`define HSDIO_X_TRG_POL  4
`define HSDIO_X_TRG_EN   5
`define HSDIO_X_IN_EN    6
`define HSDIO_X_OUT_ACK  7
`define HSDIO_X_OUT_REQ  8
`define HSDIO_X_OUT_PACE 9
`define HSDIO_X_OUT_Q    10
`define HSDIO_X_SOFT_TRG 11
`define HSDIO_X_OVR      14
`define HSDIO_X_UND      16

// interrupt control word fields
`define HSDIO_I_EN_LO    0
`define HSDIO_I_EN_HI    4
`define HSDIO_I_ST_LO    5
`define HSDIO_I_ST_HI    9
`define HSDIO_I_CHAIN0   10
`define HSDIO_I_CHAIN1   11
`define HSDIO_I_EDGE     12
`define HSDIO_I_QCLR     13
`define HSDIO_I_QEMPTY   14
`define HSDIO_I_QFULL    15

`endif
